// [alu_flag_consts.svh]
// constants for the status flag block
// assumes inclusion by alu_flag_pkg and alu_status_flag_logic
// How it works
// - overflow when top carry-in differs from carry-out
// - negative is raw adder top bit
// - zero reflects the word actually written
// - carry is adder carry out
// - subtract and steps use one adder
// - only arithmetic, logical, explicit writes change flags
// - freeze blocks all but special register move
// - trapping result is still written
// - second saved pc holds trapping address
// - signed overflow trap leaves overflow set
// - unsigned overflow trap leaves carry set
// - unsigned underflow trap leaves carry clear
// - logical ops keep overflow and carry
// - logical negative is result top bit
// - logical zero when result all zero
// - carry feeds extended add, negative feeds divide
// - conditional jumps test register booleans only
// - concatenation puts first operand high
// - trap carries field or fixed vector
// - load/store carry enable and 7-bit control
`ifndef ALU_FLAG_CONSTS_SVH
`define ALU_FLAG_CONSTS_SVH
`define WORD_W 32
`define MSB 31
`define PC_W 30
`define VEC_W 8
`define CNTL_W 7
`define VEC_OUT_OF_RANGE 8'h11
`define FLAGS_RESET 4'h0
`define FLAG_V 3
`define FLAG_N 2
`define FLAG_Z 1
`define FLAG_C 0
`define ZERO_WORD 32'h0000_0000
`endif

// [alu_flag_pkg.sv]
// types for the status flag block
// assumes the constants header is present
`include "alu_flag_consts.svh"
package alu_flag_pkg;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ARITH,
    OP_LOGIC,
    OP_MTSR
  } op_class_t;
  typedef enum logic [2:0] {
    ADD_PLAIN,
    ADD_CARRY,
    SUB_TWOS,
    SUB_ONES,
    MUL_STEP,
    DIV_STEP
  } add_mode_t;
  typedef enum logic [1:0] {
    RANGE_NONE,
    RANGE_SIGNED,
    RANGE_UNS_ADD,
    RANGE_UNS_SUB
  } range_chk_t;
  typedef enum logic [1:0] {
    LOG_AND,
    LOG_OR,
    LOG_XOR,
    LOG_CONCAT
  } log_op_t;
endpackage

// [alu_status_flag_logic.sv]
// status flag generation for a 32-bit integer execution unit
// assumes pipeline presents one instruction per valid cycle, same clock
`timescale 1ns/1ps
`default_nettype none
`include "alu_flag_consts.svh"
module alu_status_flag_logic (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instValid,
  input wire alu_flag_pkg::op_class_t opClass,
  input wire alu_flag_pkg::add_mode_t addMode,
  input wire alu_flag_pkg::log_op_t logOp,
  input wire alu_flag_pkg::range_chk_t rangeChk,
  input wire logic [`WORD_W-1:0] srcA,
  input wire logic [`WORD_W-1:0] srcB,
  input wire logic [3:0] mtsrFlags,
  input wire logic statusFreezeFlag,
  input wire logic [`PC_W-1:0] instPc,
  input wire logic trapInstr,
  input wire logic [`VEC_W-1:0] trapVectorField,
  input wire logic boolReg,
  input wire logic memInstr,
  input wire logic coprocEnable,
  input wire logic [`CNTL_W-1:0] accessCntl,
  output logic [`WORD_W-1:0] destData,
  output logic destWrite,
  output logic flagV,
  output logic flagN,
  output logic flagZ,
  output logic flagC,
  output logic trapReq,
  output logic [`VEC_W-1:0] trapVector,
  output logic [`PC_W-1:0] savedPc2,
  output logic jumpTaken,
  output logic memReq,
  output logic memCoproc,
  output logic [`CNTL_W-1:0] memCntl
);
  import alu_flag_pkg::*;

  // ----------------------------------------
  // adder datapath
  // ----------------------------------------
  logic [`WORD_W-1:0] addB;
  logic carryIn;
  logic [`WORD_W:0] sum;
  logic [`WORD_W-1:0] addRes;
  logic carryOut;
  logic carryTop;
  logic [`WORD_W-1:0] writeRes;
  logic [`WORD_W-1:0] logRes;
  logic [2*`WORD_W-1:0] concatRes;
  logic outOfRange;

  function automatic logic isZero(input logic [`WORD_W-1:0] w);
    isZero = (w == `ZERO_WORD);
  endfunction

  always_comb
  begin
    addB = srcB;
    carryIn = 1'b0;
    case (addMode)
      ADD_CARRY: carryIn = flagC;
      SUB_TWOS:
      begin
        addB = ~srcB;
        carryIn = 1'b1;
      end
      SUB_ONES: addB = ~srcB;
      DIV_STEP: if (!flagN) addB = ~srcB;
      default: addB = srcB;
    endcase
    if (addMode == DIV_STEP && !flagN)
      carryIn = 1'b1;
  end

  assign sum = {1'b0, srcA} + {1'b0, addB} + {{`WORD_W{1'b0}}, carryIn};
  assign addRes = sum[`WORD_W-1:0];
  assign carryOut = sum[`WORD_W];
  assign carryTop = srcA[`MSB] ^ addB[`MSB] ^ addRes[`MSB];

  // step ops shift after the add; flags see the shifted word only for zero
  always_comb
  begin
    case (addMode)
      MUL_STEP: writeRes = {addRes[`MSB-1:0], 1'b0};
      DIV_STEP: writeRes = {addRes[`MSB-1:0], 1'b0};
      default: writeRes = addRes;
    endcase
  end

  // ----------------------------------------
  // logical datapath
  // ----------------------------------------
  always_comb
  begin
    concatRes = {srcA, srcB};
    case (logOp)
      LOG_AND: logRes = srcA & srcB;
      LOG_OR: logRes = srcA | srcB;
      LOG_XOR: logRes = srcA ^ srcB;
      LOG_CONCAT: logRes = concatRes[`WORD_W-1:0];
      default: logRes = srcA;
    endcase
  end

  always_comb
  begin
    case (rangeChk)
      RANGE_SIGNED: outOfRange = carryTop ^ carryOut;
      RANGE_UNS_ADD: outOfRange = carryOut;
      RANGE_UNS_SUB: outOfRange = ~carryOut;
      default: outOfRange = 1'b0;
    endcase
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flagV <= 1'b0;
      flagN <= 1'b0;
      flagZ <= 1'b0;
      flagC <= 1'b0;
    end
    else if (instValid)
    begin
      case (opClass)
        OP_MTSR:
        begin
          flagV <= mtsrFlags[`FLAG_V];
          flagN <= mtsrFlags[`FLAG_N];
          flagZ <= mtsrFlags[`FLAG_Z];
          flagC <= mtsrFlags[`FLAG_C];
        end
        OP_ARITH:
          if (!statusFreezeFlag)
          begin
            flagV <= carryTop ^ carryOut;
            flagN <= addRes[`MSB];
            flagZ <= isZero(writeRes);
            flagC <= carryOut;
          end
        OP_LOGIC:
          if (!statusFreezeFlag)
          begin
            flagN <= logRes[`MSB];
            flagZ <= isZero(logRes);
          end
        default:
          flagV <= flagV;
      endcase
    end
  end

  // ----------------------------------------
  // destination write
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      destData <= `ZERO_WORD;
      destWrite <= 1'b0;
    end
    else
    begin
      destWrite <= instValid && (opClass == OP_ARITH || opClass == OP_LOGIC);
      if (instValid && opClass == OP_ARITH)
        destData <= writeRes;
      else if (instValid && opClass == OP_LOGIC)
        destData <= logRes;
    end
  end

  // ----------------------------------------
  // traps
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trapReq <= 1'b0;
      trapVector <= `VEC_W'(0);
      savedPc2 <= `PC_W'(0);
    end
    else
    begin
      trapReq <= 1'b0;
      if (instValid && opClass == OP_ARITH && outOfRange)
      begin
        trapReq <= 1'b1;
        trapVector <= `VEC_OUT_OF_RANGE;
        savedPc2 <= instPc;
      end
      else if (instValid && trapInstr)
      begin
        trapReq <= 1'b1;
        trapVector <= trapVectorField;
        savedPc2 <= instPc;
      end
    end
  end

  // ----------------------------------------
  // jumps and memory access
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      jumpTaken <= 1'b0;
      memReq <= 1'b0;
      memCoproc <= 1'b0;
      memCntl <= `CNTL_W'(0);
    end
    else
    begin
      jumpTaken <= instValid && boolReg;
      memReq <= instValid && memInstr;
      if (instValid && memInstr)
      begin
        memCoproc <= coprocEnable;
        memCntl <= accessCntl;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_freeze_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (statusFreezeFlag && !(instValid && opClass == OP_MTSR)) |=> $stable({flagV, flagN, flagZ, flagC}))
    else $error("flags changed while frozen");
  chk_logic_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_LOGIC) |=> $stable({flagV, flagC}))
    else $error("logical op changed v or c");
  chk_other_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (!instValid || opClass == OP_NONE) |=> $stable({flagV, flagN, flagZ, flagC}))
    else $error("flags changed by other op");
  chk_signed_trap: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_ARITH && rangeChk == RANGE_SIGNED && outOfRange
     && !statusFreezeFlag) |=> (trapReq && flagV))
    else $error("signed trap without v");
  chk_uadd_trap: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_ARITH && rangeChk == RANGE_UNS_ADD && outOfRange
     && !statusFreezeFlag) |=> (trapReq && flagC))
    else $error("unsigned add trap without c");
  chk_usub_trap: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_ARITH && rangeChk == RANGE_UNS_SUB && outOfRange
     && !statusFreezeFlag) |=> (trapReq && !flagC))
    else $error("unsigned sub trap with c");
  chk_trap_pc: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_ARITH && outOfRange) |=> (savedPc2 == $past(instPc)))
    else $error("saved pc wrong");
  chk_zero_write: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_ARITH && !statusFreezeFlag) |=> (flagZ == (destData == `ZERO_WORD)))
    else $error("zero flag disagrees with written word");
  chk_commit_same: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_ARITH) |=> (destWrite && destData == $past(writeRes)))
    else $error("result not committed with flags");

  // ----------------------------------------
  // datapath and side output checks
  // ----------------------------------------
  chk_v_arith: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_ARITH && !statusFreezeFlag)
    |=> (flagV == $past(srcA[`MSB] == addB[`MSB] && addRes[`MSB] != srcA[`MSB])))
    else $error("overflow flag wrong");
  chk_n_raw: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_ARITH && !statusFreezeFlag)
    |=> (flagN == $past(addRes[`MSB])))
    else $error("negative flag not raw adder bit");
  chk_z_step: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_ARITH && !statusFreezeFlag && addMode == MUL_STEP)
    |=> (flagZ == ($past(addRes[`MSB-1:0]) == '0)))
    else $error("zero flag ignores step shift");
  chk_c_carry: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_ARITH && !statusFreezeFlag)
    |=> (flagC == $past(addRes < srcA || (carryIn && addRes == srcA))))
    else $error("carry flag wrong");
  chk_add_plain: assert property (@(posedge clk) disable iff (!rst_n)
    (addMode == ADD_PLAIN) |-> (addRes == srcA + srcB))
    else $error("plain add wrong");
  chk_sub_twos: assert property (@(posedge clk) disable iff (!rst_n)
    (addMode == SUB_TWOS) |-> (addRes == srcA - srcB))
    else $error("twos subtract wrong");
  chk_sub_ones: assert property (@(posedge clk) disable iff (!rst_n)
    (addMode == SUB_ONES) |-> (addRes == srcA + ~srcB))
    else $error("ones subtract wrong");
  chk_carry_chain: assert property (@(posedge clk) disable iff (!rst_n)
    (addMode == ADD_CARRY) |-> (addRes == srcA + srcB + `WORD_W'(flagC)))
    else $error("carry not chained");
  chk_div_dir: assert property (@(posedge clk) disable iff (!rst_n)
    (addMode == DIV_STEP) |-> (addRes == (flagN ? srcA + srcB : srcA - srcB)))
    else $error("divide step direction wrong");
  chk_mtsr_write: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_MTSR) |=> ({flagV, flagN, flagZ, flagC} == $past(mtsrFlags)))
    else $error("special move not written");
  chk_trap_write: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_ARITH && outOfRange && addMode == ADD_PLAIN)
    |=> (destWrite && destData == $past(srcA + srcB)))
    else $error("trapping result not written");
  chk_logic_n: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_LOGIC && !statusFreezeFlag)
    |=> (flagN == $past(logRes[`MSB])))
    else $error("logical negative wrong");
  chk_logic_z: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_LOGIC && !statusFreezeFlag)
    |=> (flagZ == ($past(logRes) == `ZERO_WORD)))
    else $error("logical zero wrong");
  chk_jump_bool: assert property (@(posedge clk) disable iff (!rst_n)
    instValid |=> (jumpTaken == $past(boolReg)))
    else $error("jump not from register boolean");
  chk_jump_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !instValid |=> !jumpTaken)
    else $error("jump without instruction");
  chk_concat_order: assert property (@(posedge clk) disable iff (!rst_n)
    (logOp == LOG_CONCAT) |-> (concatRes[2*`WORD_W-1:`WORD_W] == srcA && logRes == srcB))
    else $error("concatenation order wrong");
  chk_trap_vec: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && trapInstr && !(opClass == OP_ARITH && outOfRange))
    |=> (trapReq && trapVector == $past(trapVectorField)))
    else $error("trap vector field lost");
  chk_range_vec: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_ARITH && outOfRange) |=> (trapVector == `VEC_OUT_OF_RANGE))
    else $error("range trap vector wrong");
  chk_trap_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !instValid |=> !trapReq)
    else $error("trap without instruction");
  chk_mem_ctl: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && memInstr)
    |=> (memReq && {memCoproc, memCntl} == $past({coprocEnable, accessCntl})))
    else $error("access control not passed");
  chk_mem_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !(instValid && memInstr) |=> !memReq)
    else $error("access without load or store");
  chk_logic_write: assert property (@(posedge clk) disable iff (!rst_n)
    (instValid && opClass == OP_LOGIC) |=> (destWrite && destData == $past(logRes)))
    else $error("logical result not committed");
  chk_idle_nowrite: assert property (@(posedge clk) disable iff (!rst_n)
    !instValid |=> !destWrite)
    else $error("write without instruction");
endmodule
`default_nettype wire

// [exec_pipe_model.sv]
// random instruction source standing in for the execution pipeline
// assumes the flag block samples its inputs on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module exec_pipe_model (
  input wire logic clk,
  input wire logic rst_n,
  output var logic instValid,
  output var alu_flag_pkg::op_class_t opClass,
  output var alu_flag_pkg::add_mode_t addMode,
  output var alu_flag_pkg::log_op_t logOp,
  output var alu_flag_pkg::range_chk_t rangeChk,
  output var logic [31:0] srcA,
  output var logic [31:0] srcB,
  output var logic [3:0] mtsrFlags,
  output var logic statusFreezeFlag,
  output var logic [29:0] instPc,
  output var logic trapInstr,
  output var logic [7:0] trapVectorField,
  output var logic boolReg,
  output var logic memInstr,
  output var logic coprocEnable,
  output var logic [6:0] accessCntl
);
  import alu_flag_pkg::*;
  op_class_t cls;
  // boundary operands come up often
  function automatic logic [31:0] pick();
    logic [31:0] e [4];
    e = '{32'h0000_0000, 32'h7fff_ffff, 32'h8000_0000, 32'hffff_ffff};
    pick = ($urandom % 3 == 0) ? e[$urandom % 4] : $urandom;
  endfunction
  initial
  begin
    void'($urandom(55979));
    {instValid, opClass, addMode, logOp, rangeChk, srcA, srcB, mtsrFlags} = '0;
    {statusFreezeFlag, instPc, trapInstr, trapVectorField} = '0;
    {boolReg, memInstr, coprocEnable, accessCntl} = '0;
    // at most one instruction a cycle, instValid low about one cycle in eight; idle while in reset
    forever
    begin
      @(posedge clk);
      if (rst_n)
      begin
        cls = op_class_t'($urandom % 4);
        instValid <= ($urandom % 8) != 0;
        opClass <= cls;
        addMode <= add_mode_t'($urandom % 6);
        logOp <= log_op_t'($urandom % 4);
        rangeChk <= range_chk_t'($urandom % 4);
        srcA <= pick();
        srcB <= pick();
        mtsrFlags <= 4'($urandom);
        statusFreezeFlag <= ($urandom % 6) == 0;
        instPc <= 30'($urandom);
        trapInstr <= cls == OP_NONE && 1'($urandom);
        trapVectorField <= 8'($urandom);
        boolReg <= 1'($urandom);
        memInstr <= 1'($urandom);
        coprocEnable <= 1'($urandom);
        accessCntl <= 7'($urandom);
      end
      else
        instValid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [alu_status_flag_logic_test.sv]
// self-checking bench: flag block against a reference model
// assumes exec_pipe_model supplies the instruction stream
`timescale 1ns/1ps
`default_nettype none
`include "alu_flag_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module alu_status_flag_logic_test;
  import alu_flag_pkg::*;
  logic clk = 0, rst_n = 0, run = 0;
  int num_errors = 0, samples_checked = 0;
  logic instValid, statusFreezeFlag, trapInstr, boolReg, memInstr, coprocEnable;
  op_class_t opClass;
  add_mode_t addMode;
  log_op_t logOp;
  range_chk_t rangeChk;
  logic [31:0] srcA, srcB, destData, bOp, res, eD, wr;
  logic [3:0] mtsrFlags, ef;
  logic [29:0] instPc, savedPc2, ePc;
  logic [7:0] trapVectorField, trapVector, eVec;
  logic [6:0] accessCntl, memCntl, eCn;
  logic destWrite, flagV, flagN, flagZ, flagC, trapReq, jumpTaken, memReq, memCoproc;
  logic [32:0] sum;
  logic cin, vNew, tr, eT, eOr, eW, eM, eCp, eJ, stepSub;
  always #4 clk = ~clk;
  exec_pipe_model exec_pipe_model_i (.clk(clk), .rst_n(rst_n), .instValid(instValid),
    .opClass(opClass), .addMode(addMode), .logOp(logOp), .rangeChk(rangeChk), .srcA(srcA),
    .srcB(srcB), .mtsrFlags(mtsrFlags), .statusFreezeFlag(statusFreezeFlag), .instPc(instPc),
    .trapInstr(trapInstr), .trapVectorField(trapVectorField), .boolReg(boolReg),
    .memInstr(memInstr), .coprocEnable(coprocEnable), .accessCntl(accessCntl));
  alu_status_flag_logic alu_status_flag_logic_i (.clk(clk), .rst_n(rst_n),
    .instValid(instValid), .opClass(opClass), .addMode(addMode), .logOp(logOp),
    .rangeChk(rangeChk), .srcA(srcA), .srcB(srcB), .mtsrFlags(mtsrFlags),
    .statusFreezeFlag(statusFreezeFlag), .instPc(instPc), .trapInstr(trapInstr),
    .trapVectorField(trapVectorField), .boolReg(boolReg), .memInstr(memInstr),
    .coprocEnable(coprocEnable), .accessCntl(accessCntl), .destData(destData),
    .destWrite(destWrite), .flagV(flagV), .flagN(flagN), .flagZ(flagZ), .flagC(flagC),
    .trapReq(trapReq), .trapVector(trapVector), .savedPc2(savedPc2),
    .jumpTaken(jumpTaken), .memReq(memReq), .memCoproc(memCoproc), .memCntl(memCntl));
  // ------------------------------
  // reference model
  // ------------------------------
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      {ef, eD, eT, eOr, eW, eVec, ePc, eM, eCn, eCp, eJ} = '0;
    else
    begin
      {eT, eOr, eW, eM, eJ} = '0;
      if (instValid)
      begin
        stepSub = addMode == DIV_STEP && !ef[2];
        bOp = (addMode == SUB_TWOS || addMode == SUB_ONES || stepSub) ? ~srcB : srcB;
        cin = addMode == SUB_TWOS || stepSub || (addMode == ADD_CARRY && ef[0]);
        sum = {1'b0, srcA} + {1'b0, bOp} + {32'h0000_0000, cin};
        wr = (addMode == MUL_STEP || addMode == DIV_STEP) ? {sum[30:0], 1'b0} : sum[31:0];
        vNew = sum[32] ^ sum[31] ^ srcA[31] ^ bOp[31];
        tr = opClass == OP_ARITH && ((rangeChk == RANGE_SIGNED && vNew) ||
          (rangeChk == RANGE_UNS_ADD && sum[32]) || (rangeChk == RANGE_UNS_SUB && !sum[32]));
        res = logOp == LOG_AND ? srcA & srcB : logOp == LOG_OR ? srcA | srcB :
          logOp == LOG_XOR ? srcA ^ srcB : srcB;
        if (opClass == OP_MTSR)
          ef = mtsrFlags;
        else if (!statusFreezeFlag && opClass == OP_ARITH)
          ef = {vNew, sum[31], wr == 0, sum[32]};
        else if (!statusFreezeFlag && opClass == OP_LOGIC)
          ef[2:1] = {res[31], res == 0};
        eW = opClass == OP_ARITH || opClass == OP_LOGIC;
        if (opClass == OP_ARITH)
          eD = wr;
        else if (opClass == OP_LOGIC)
          eD = res;
        eT = tr || trapInstr;
        eOr = tr;
        if (eT)
          eVec = tr ? `VEC_OUT_OF_RANGE : trapVectorField;
        if (tr)
          ePc = instPc;
        eM = memInstr;
        eJ = boolReg;
        if (memInstr)
          {eCp, eCn} = {coprocEnable, accessCntl};
      end
    end
  // ------------------------------
  // comparisons
  // ------------------------------
  always @(negedge clk)
    if (run)
    begin
      `CHK(flagV, ef[3])
      `CHK(flagN, ef[2])
      `CHK(flagZ, ef[1])
      `CHK(flagC, ef[0])
      `CHK(destData, eD)
      `CHK(destWrite, eW)
      `CHK(trapReq, eT)
      `CHK(memReq, eM)
      `CHK(jumpTaken, eJ)
      if (eT)
        `CHK(trapVector, eVec)
      if (eOr)
        `CHK(savedPc2, ePc)
      if (eM)
        `CHK({memCoproc, memCntl}, {eCp, eCn})
    end
  task automatic final_report;
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    run <= 1;
    repeat (2000) @(posedge clk);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (2000) @(posedge clk);
    final_report;
  end
  initial
  begin
    #(8 * 6000);
    num_errors++;
    final_report;
  end
endmodule
`default_nettype wire
